// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import period_match_timer8_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = '0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        sleep = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        match_pulse, pwm_time_base, spi_shift_clock, irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #20 aclk = ~aclk;

  period_match_timer8 dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep(sleep),
    .match_pulse(match_pulse), .pwm_time_base(pwm_time_base),
    .spi_shift_clock(spi_shift_clock), .irq(irq)
  );

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // both channels offered together, each dropped as soon as it is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    chk_val("bvalid", 1'b1, s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    chk_val("rvalid", 1'b1, s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, {24'h0, d}, r);
    chk_val("bresp", RESP_OKAY, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_val(what, exp, d);
  endtask

  // cycles between two consecutive match pulses; the first gap after a write is skipped
  task automatic gap(output int g);
    int n;
    n = 0;
    do @(posedge aclk); while (!match_pulse && n++ < 20000);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (!match_pulse && g < 20000);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk("control", CONTROL_OFFSET, {24'h0, CONTROL_RESET});
    rd_chk("count", COUNT_OFFSET, 32'h0);
    rd_chk("period", PERIOD_OFFSET, 32'hFF);
    rd(8'h20, d, r);
    chk_val("unmapped rresp", RESP_SLVERR, r);
    chk_val("irq", 1'b0, irq);
  endtask

  task automatic t_prescale;
    int g;
    wr_ok(PERIOD_OFFSET, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr_ok(CONTROL_OFFSET, 8'h04 | c[7:0]);
      gap(g);
      gap(g);
      chk_val("period cycles", QUARTER_DIV * (1 << (2 * c)) * 2, g);
      chk_val("pwm base", 1'b1, pwm_time_base);
      chk_val("spi clock", 1'b1, spi_shift_clock);
    end
    rd_chk("count after match", COUNT_OFFSET, 32'h0);
  endtask

  task automatic t_post;
    logic [3:0] sel [3] = '{4'h0, 4'h2, 4'hF};
    int np;
    int n;
    wr_ok(ENABLE_OFFSET, 8'h01);
    foreach (sel[i]) begin
      wr_ok(CONTROL_OFFSET, 8'h00);
      wr_ok(FLAG_OFFSET, 8'h01);
      chk_val("irq cleared", 1'b0, irq);
      wr_ok(COUNT_OFFSET, 8'h00);
      wr_ok(CONTROL_OFFSET, {1'b0, sel[i], 3'b100});
      np = 0;
      n = 0;
      while (!irq && n++ < 2000) begin
        @(posedge aclk);
        if (match_pulse) np++;
      end
      chk_val("matches per flag", sel[i] + 1, np);
    end
    rd_chk("flag", FLAG_OFFSET, 32'h1);
    wr_ok(ENABLE_OFFSET, 8'h00);
    chk_val("irq masked", 1'b0, irq);
    wr_ok(CONTROL_OFFSET, 8'h00);
    wr_ok(FLAG_OFFSET, 8'h01);
    rd_chk("flag w1c", FLAG_OFFSET, 32'h0);
  endtask

  task automatic t_hold;
    logic [31:0] c1, c2;
    logic [1:0]  r;
    wr_ok(PERIOD_OFFSET, 8'hFF);
    wr_ok(CONTROL_OFFSET, 8'h04);
    repeat (40) @(posedge aclk);
    wr_ok(CONTROL_OFFSET, 8'h00);
    rd(COUNT_OFFSET, c1, r);
    repeat (40) @(posedge aclk);
    rd_chk("count stopped", COUNT_OFFSET, c1);
    wr_ok(COUNT_OFFSET, 8'h5A);
    rd_chk("count written", COUNT_OFFSET, 32'h5A);
    wr_ok(CONTROL_OFFSET, 8'hFB);
    rd_chk("count kept", COUNT_OFFSET, 32'h5A);
    rd_chk("control bit7", CONTROL_OFFSET, 32'h7B);
    wr_ok(CONTROL_OFFSET, 8'h04);
    @(posedge aclk);
    sleep <= 1'b1;
    rd(COUNT_OFFSET, c1, r);
    repeat (40) @(posedge aclk);
    rd_chk("count asleep", COUNT_OFFSET, c1);
    rd_chk("period asleep", PERIOD_OFFSET, 32'hFF);
    @(posedge aclk);
    sleep <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(COUNT_OFFSET, c2, r);
    chk_val("count resumes", 1'b1, c2 !== c1);
  endtask

  // reset in mid-run while the timer is counting
  task automatic t_rst2;
    wr_ok(PERIOD_OFFSET, 8'h33);
    wr_ok(CONTROL_OFFSET, 8'h04);
    repeat (40) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("count after reset", COUNT_OFFSET, 32'h0);
    rd_chk("period after reset", PERIOD_OFFSET, {24'h0, PERIOD_RESET});
    rd_chk("control after reset", CONTROL_OFFSET, {24'h0, CONTROL_RESET});
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // longest path is the /64 prescale gaps, 512 cycles each
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_prescale();
    t_post();
    t_hold();
    t_rst2();
    finish_test();
  end
endmodule
`default_nettype wire

// File: rtl/clock_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler
  import period_match_timer8_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  scaler_if.unit    sc
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [5:0] limit;

  always_comb begin
    unique case (sc.ckps)
      2'b00: limit = 6'h00;
      2'b01: limit = 6'h03;
      2'b10: limit = 6'h0F;
      2'b11: limit = 6'h3F;
    endcase
    next_cnt    = cnt;
    sc.pre_tick = 1'b0;
    if (sc.clear) begin
      next_cnt = 6'h00;
    end else if (sc.tick && sc.run) begin
      if (cnt >= limit) begin
        next_cnt    = 6'h00;
        sc.pre_tick = 1'b1;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  a_pre_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    sc.clear |=> cnt == 6'h00)
    else $error("prescaler not cleared");
endmodule
`default_nettype wire

// File: rtl/period_match_timer8.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - count clock is instruction clock, aclk/4
// - prescale codes divide by 1,4,16,64
// - compare count with period each prescaled tick
// - match pulses output, count zero next tick
// - postscaler ratio is select plus one
// - postscaler terminal count sets sticky flag
// - interrupt only while enable bit set
// - reset clears count, period to all ones
// - count/control writes and reset clear scalers
// - control write keeps the count
// - count and period freely readable, writable
// - unscaled match pulse goes to pwm
// - timer output offered as spi clock
// - sleep freezes counting, registers kept
// - period is period value plus one
module period_match_timer8
  import period_match_timer8_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep,
  output logic             match_pulse,
  output logic             pwm_time_base,
  output logic             spi_shift_clock,
  output logic             irq
);
  logic [7:0] timer_count;
  logic [7:0] next_timer_count;
  logic [7:0] period_value;
  logic [7:0] next_period_value;
  logic [7:0] timer_control;
  logic [7:0] next_timer_control;
  logic [3:0] post_cnt;
  logic [3:0] next_post_cnt;
  logic       match_interrupt_flag;
  logic       next_match_interrupt_flag;
  logic       match_interrupt_enable;
  logic       next_match_interrupt_enable;
  logic [1:0] quarter;
  logic [1:0] next_quarter;

  logic       aw_held;
  logic       next_aw_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic       w_held;
  logic       next_w_held;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic       w_lane;
  logic       next_w_lane;
  logic       bvalid;
  logic       next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic       rvalid;
  logic       next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  logic       wr_fire;
  logic       wr_count;
  logic       wr_control;
  logic       wr_period;
  logic       wr_flag;
  logic       wr_enable;
  logic       post_done;
  logic       cmp_equal;

  scaler_if sc ();

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CONTROL_OFFSET) || (a == COUNT_OFFSET) || (a == PERIOD_OFFSET)
          || (a == FLAG_OFFSET) || (a == ENABLE_OFFSET);
  endfunction

  clock_prescaler u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sc      (sc.unit)
  );

  // bus: address and data latched independently, response once both are held
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  assign wr_fire    = aw_held && w_held && !bvalid;
  assign wr_count   = wr_fire && w_lane && aw_addr == COUNT_OFFSET;
  assign wr_control = wr_fire && w_lane && aw_addr == CONTROL_OFFSET;
  assign wr_period  = wr_fire && w_lane && aw_addr == PERIOD_OFFSET;
  assign wr_flag    = wr_fire && w_lane && aw_addr == FLAG_OFFSET;
  assign wr_enable  = wr_fire && w_lane && aw_addr == ENABLE_OFFSET;

  // quarter-rate tick stands for the instruction clock; frozen during sleep
  always_comb begin
    next_quarter = quarter;
    sc.tick      = 1'b0;
    if (!sleep) begin
      if (quarter == 2'(QUARTER_DIV - 1)) begin
        next_quarter = 2'b00;
        sc.tick      = 1'b1;
      end else begin
        next_quarter = quarter + 2'b01;
      end
    end
  end

  assign sc.clear = wr_count || wr_control;
  assign sc.ckps  = timer_control[CKPS_LSB +: 2];
  assign sc.run   = timer_control[RUN_BIT];

  assign cmp_equal = timer_count == period_value;

  always_comb begin
    next_timer_count = timer_count;
    if (wr_count) begin
      next_timer_count = w_data;
    end else if (sc.pre_tick) begin
      // count sits at the period for one full tick, then wraps on the next
      next_timer_count = cmp_equal ? COUNT_RESET : timer_count + 8'h01;
    end
  end

  // output pulse lasts one aclk at the tick where the match was seen
  assign match_pulse     = sc.pre_tick && cmp_equal;
  assign pwm_time_base   = match_pulse;
  assign spi_shift_clock = match_pulse;

  assign post_done = match_pulse && post_cnt == timer_control[OUTPS_LSB +: 4];

  always_comb begin
    next_post_cnt = post_cnt;
    if (sc.clear) begin
      next_post_cnt = 4'h0;
    end else if (match_pulse) begin
      next_post_cnt = post_done ? 4'h0 : post_cnt + 4'h1;
    end
  end

  always_comb begin
    next_timer_control          = timer_control;
    next_period_value           = period_value;
    next_match_interrupt_flag   = match_interrupt_flag;
    next_match_interrupt_enable = match_interrupt_enable;
    if (wr_control) begin
      next_timer_control = w_data & CONTROL_WMASK;
    end
    if (wr_period) begin
      next_period_value = w_data;
    end
    if (wr_enable) begin
      next_match_interrupt_enable = w_data[FLAG_BIT];
    end
    if (wr_flag && w_data[FLAG_BIT]) begin
      next_match_interrupt_flag = 1'b0;
    end
    // set wins over a simultaneous clear
    if (post_done) begin
      next_match_interrupt_flag = 1'b1;
    end
  end

  assign irq = match_interrupt_flag && match_interrupt_enable;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane  = w_lane;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        CONTROL_OFFSET: next_rdata = {24'h000000, timer_control};
        COUNT_OFFSET:   next_rdata = {24'h000000, timer_count};
        PERIOD_OFFSET:  next_rdata = {24'h000000, period_value};
        FLAG_OFFSET:    next_rdata = {31'h00000000, match_interrupt_flag};
        ENABLE_OFFSET:  next_rdata = {31'h00000000, match_interrupt_enable};
        default:        next_rdata = 32'h00000000;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count            <= COUNT_RESET;
      period_value           <= PERIOD_RESET;
      timer_control          <= CONTROL_RESET;
      post_cnt               <= 4'h0;
      match_interrupt_flag   <= 1'b0;
      match_interrupt_enable <= 1'b0;
      quarter                <= 2'b00;
      aw_held                <= 1'b0;
      aw_addr                <= 8'h00;
      w_held                 <= 1'b0;
      w_data                 <= 8'h00;
      w_lane                 <= 1'b0;
      bvalid                 <= 1'b0;
      bresp                  <= RESP_OKAY;
      rvalid                 <= 1'b0;
      rdata                  <= 32'h00000000;
      rresp                  <= RESP_OKAY;
    end else begin
      timer_count            <= next_timer_count;
      period_value           <= next_period_value;
      timer_control          <= next_timer_control;
      post_cnt               <= next_post_cnt;
      match_interrupt_flag   <= next_match_interrupt_flag;
      match_interrupt_enable <= next_match_interrupt_enable;
      quarter                <= next_quarter;
      aw_held                <= next_aw_held;
      aw_addr                <= next_aw_addr;
      w_held                 <= next_w_held;
      w_data                 <= next_w_data;
      w_lane                 <= next_w_lane;
      bvalid                 <= next_bvalid;
      bresp                  <= next_bresp;
      rvalid                 <= next_rvalid;
      rdata                  <= next_rdata;
      rresp                  <= next_rresp;
    end
  end

  a_match_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    match_pulse && !wr_count |=> timer_count == 8'h00)
    else $error("count not reloaded after match");
  a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
    sc.pre_tick && !wr_count && !cmp_equal |=> timer_count == $past(timer_count) + 8'h01)
    else $error("count did not step");
  a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    post_done |=> match_interrupt_flag)
    else $error("flag not set");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq) |-> $past(post_done) || $past(wr_enable))
    else $error("irq rose without set or enable");
  a_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep && !wr_count && $past(sleep) |=> $stable(timer_count))
    else $error("count moved in sleep");
  a_ctrl_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_control |=> $stable(timer_count))
    else $error("control write disturbed count");
  a_run_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !sc.run && !wr_count |=> $stable(timer_count))
    else $error("count moved while stopped");
  a_tick_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    sc.tick |=> !sc.tick [*3])
    else $error("instruction tick too fast");
  a_post_one: assert property (@(posedge aclk) disable iff (!aresetn)
    match_pulse && timer_control[OUTPS_LSB +: 4] == 4'h0 |-> post_done)
    else $error("1:1 postscale missed");

  c_match: cover property (@(posedge aclk) disable iff (!aresetn) match_pulse);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
  c_set_clear: cover property (@(posedge aclk) disable iff (!aresetn) post_done && wr_flag);
  c_sleep: cover property (@(posedge aclk) disable iff (!aresetn) sleep && sc.run);
endmodule
`default_nettype wire

// File: rtl/period_match_timer8_pkg.sv
package period_match_timer8_pkg;
  localparam logic [7:0] CONTROL_OFFSET   = 8'h00;
  localparam logic [7:0] COUNT_OFFSET     = 8'h04;
  localparam logic [7:0] PERIOD_OFFSET    = 8'h08;
  localparam logic [7:0] FLAG_OFFSET      = 8'h0C;
  localparam logic [7:0] ENABLE_OFFSET    = 8'h10;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET      = 8'h00;
  localparam logic [7:0] PERIOD_RESET     = 8'hFF;
  localparam int         CKPS_LSB         = 0;
  localparam int         RUN_BIT          = 2;
  localparam int         OUTPS_LSB        = 3;
  localparam int         QUARTER_DIV      = 4;
  localparam int         FLAG_BIT         = 0;
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;
  localparam logic [7:0] CONTROL_WMASK    = 8'h7F;
endpackage

// File: rtl/scaler_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scaler_if;
  logic       tick;
  logic       clear;
  logic [1:0] ckps;
  logic       run;
  logic       pre_tick;
  modport ctrl (output tick, output clear, output ckps, output run, input pre_tick);
  modport unit (input tick, input clear, input ckps, input run, output pre_tick);
endinterface
`default_nettype wire
